// ---- core/nibble_swap_pkg.sv ----
// constants, field layouts and state codes for the nibble exchange execution block
// assumes a single 20 MHz core clock and a 4096-byte data file
package nibble_swap_pkg;
  // ----------------------------------------------------------------
  // instruction word layout
  // ----------------------------------------------------------------
  localparam int INSTR_W = 16;
  localparam int OPC_HI = 15;
  localparam int OPC_LO = 10;
  localparam logic [5:0] NIBBLE_EXCHANGE_OP = 6'h0E;
  localparam int DEST_BIT = 9;
  localparam int BANK_BIT = 8;
  localparam int FIELD_HI = 7;
  localparam int FIELD_LO = 0;
  // ----------------------------------------------------------------
  // data file addressing
  // ----------------------------------------------------------------
  localparam int DATA_W = 8;
  localparam int BANK_W = 4;
  localparam int ADDR_W = 12;
  localparam int FILE_DEPTH = 4096;
  localparam logic [7:0] ACCESS_SPLIT = 8'h80;
  localparam logic [3:0] ACCESS_LOW_BANK = 4'h0;
  localparam logic [3:0] ACCESS_HIGH_BANK = 4'hF;
  localparam logic [7:0] OFFSET_LIMIT = 8'h5F;
  // ----------------------------------------------------------------
  // reset values and state codes
  // ----------------------------------------------------------------
  localparam logic [7:0] ACC_RESET = 8'h00;
  localparam logic [7:0] DATA_RESET = 8'h00;
  localparam logic [11:0] ADDR_RESET = 12'h000;
  typedef enum logic [1:0] {
    ST_IDLE = 2'b01,
    ST_EXEC = 2'b10
  } exec_state_type;
endpackage : nibble_swap_pkg

// ---- core/file_mem_if.sv ----
// carrier between the execution core and its data file
// assumes both ends share core_clk_i
interface file_mem_if;
  import nibble_swap_pkg::*;
  logic [ADDR_W-1:0] addr;
  logic we;
  logic [DATA_W-1:0] wdata;
  logic [DATA_W-1:0] rdata;
  modport ctrl (output addr, output we, output wdata, input rdata);
  modport mem (input addr, input we, input wdata, output rdata);
endinterface : file_mem_if

// ---- core/general_purpose_file.sv ----
// byte-wide data file, single port, registered read data
// assumes synchronous active-high reset and a clock enable
module general_purpose_file (
  input wire logic core_clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  file_mem_if.mem port
);
  import nibble_swap_pkg::*;
  logic [DATA_W-1:0] cells [FILE_DEPTH];
  logic [DATA_W-1:0] rdata_q;
  // ----------------------------------------------------------------
  // storage
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk_i) begin
    if (ce_i && port.we) begin
      cells[port.addr] <= port.wdata;
    end
  end
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      rdata_q <= DATA_RESET;
    end else if (ce_i) begin
      rdata_q <= cells[port.addr];
    end
  end
  assign port.rdata = rdata_q;
endmodule // general_purpose_file

// ---- core/nibble_swap_core.sv ----
// execution logic of the nibble exchange instruction with its data file
// assumes inputs synchronous to core_clk_i; instructions offered only while busy_o is low
//Contract
//RULE1: result takes source low nibble as high nibble and high nibble as low.
//RULE2: destination bit 0 writes result to accumulator, source byte untouched.
//RULE3: destination bit 1 writes result back to the byte it was read from.
//RULE4: bank bit 0 resolves address in the fixed common bank, ignoring bank select.
//RULE5: bank bit 1 forms address from bank select register and address field.
//RULE6: extended set, bank bit 0, field at most 95 uses indexed literal offset.
//RULE7: decode 001110da ffffffff; one word, one pass, no status flags touched.
module nibble_swap_core (
  input wire logic core_clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  input wire logic instr_valid_i,
  input wire logic [nibble_swap_pkg::INSTR_W-1:0] instr_i,
  input wire logic [nibble_swap_pkg::BANK_W-1:0] bank_select_reg_i,
  input wire logic ext_set_en_i,
  input wire logic [nibble_swap_pkg::ADDR_W-1:0] index_base_i,
  input wire logic dbg_we_i,
  input wire logic dbg_re_i,
  input wire logic [nibble_swap_pkg::ADDR_W-1:0] dbg_addr_i,
  input wire logic [nibble_swap_pkg::DATA_W-1:0] dbg_wdata_i,
  output logic busy_o,
  output logic done_o,
  output logic foreign_o,
  output logic [nibble_swap_pkg::DATA_W-1:0] acc_o,
  output logic [nibble_swap_pkg::DATA_W-1:0] result_o,
  output logic [nibble_swap_pkg::ADDR_W-1:0] eff_addr_o,
  output logic dbg_valid_o,
  output logic [nibble_swap_pkg::DATA_W-1:0] dbg_rdata_o
);
  import nibble_swap_pkg::*;

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef struct packed {
    exec_state_type st;
    logic busy;
    logic done;
    logic foreign;
    logic dest;
    logic [DATA_W-1:0] acc;
    logic [DATA_W-1:0] result;
    logic [ADDR_W-1:0] ea;
    logic dbg_pend;
    logic dbg_valid;
    logic [DATA_W-1:0] dbg_rdata;
  } core_state_type;

  core_state_type s_q;
  core_state_type s_d;
  file_mem_if mem_bus ();

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic logic [ADDR_W-1:0] resolve_addr(
    input logic bank_bit,
    input logic [7:0] field,
    input logic [BANK_W-1:0] bsel,
    input logic ext_en,
    input logic [ADDR_W-1:0] base
  );
    logic [ADDR_W-1:0] a;
    a = ADDR_RESET;
    if (bank_bit) begin
      a = {bsel, field}; // RULE5
    end else if (ext_en && (field <= OFFSET_LIMIT)) begin
      a = ADDR_W'(base + {4'h0, field}); // RULE6
    end else if (field < ACCESS_SPLIT) begin
      a = {ACCESS_LOW_BANK, field}; // RULE4
    end else begin
      a = {ACCESS_HIGH_BANK, field}; // RULE4
    end
    return a;
  endfunction

  function automatic logic [DATA_W-1:0] swap_nibbles(input logic [DATA_W-1:0] v);
    return {v[3:0], v[7:4]}; // RULE1
  endfunction

  // ----------------------------------------------------------------
  // instruction field decode
  // ----------------------------------------------------------------
  function automatic logic is_nibble_op(input logic [INSTR_W-1:0] w);
    return w[OPC_HI:OPC_LO] == NIBBLE_EXCHANGE_OP; // RULE7
  endfunction

  function automatic logic dest_of(input logic [INSTR_W-1:0] w);
    return w[DEST_BIT];
  endfunction

  function automatic logic bank_of(input logic [INSTR_W-1:0] w);
    return w[BANK_BIT];
  endfunction

  function automatic logic [7:0] field_of(input logic [INSTR_W-1:0] w);
    return w[FIELD_HI:FIELD_LO];
  endfunction

  logic is_op;
  logic accept;
  logic dest_sel;
  logic bank_sel;
  logic [7:0] field_sel;
  logic [ADDR_W-1:0] new_ea;
  logic [DATA_W-1:0] swapped;

  assign is_op = is_nibble_op(instr_i); // RULE7
  assign dest_sel = dest_of(instr_i);
  assign bank_sel = bank_of(instr_i);
  assign field_sel = field_of(instr_i);
  assign accept = instr_valid_i && (s_q.st == ST_IDLE);

  // ----------------------------------------------------------------
  // effective address
  // ----------------------------------------------------------------
  assign new_ea = resolve_addr(bank_sel, field_sel, bank_select_reg_i, ext_set_en_i,
                               index_base_i);
  assign swapped = swap_nibbles(mem_bus.rdata);

  // ----------------------------------------------------------------
  // next state and data file port
  // ----------------------------------------------------------------
  always_comb begin
    s_d = s_q;
    s_d.done = 1'b0;
    s_d.foreign = 1'b0;
    s_d.dbg_valid = 1'b0;
    s_d.dbg_pend = 1'b0;
    mem_bus.addr = dbg_addr_i;
    mem_bus.we = 1'b0;
    mem_bus.wdata = dbg_wdata_i;
    if (s_q.dbg_pend) begin
      s_d.dbg_valid = 1'b1;
      s_d.dbg_rdata = mem_bus.rdata;
    end
    case (s_q.st)
      ST_IDLE: begin
        if (accept && is_op) begin
          mem_bus.addr = new_ea;
          s_d.ea = new_ea;
          s_d.dest = dest_sel;
          s_d.st = ST_EXEC;
          s_d.busy = 1'b1;
        end else if (accept) begin
          s_d.foreign = 1'b1;
        end else if (dbg_we_i) begin
          mem_bus.we = 1'b1;
        end else if (dbg_re_i) begin
          s_d.dbg_pend = 1'b1;
        end
      end
      ST_EXEC: begin
        mem_bus.addr = s_q.ea;
        mem_bus.wdata = swapped;
        s_d.result = swapped;
        if (s_q.dest) begin
          mem_bus.we = 1'b1; // RULE3
        end else begin
          s_d.acc = swapped; // RULE2
        end
        s_d.done = 1'b1; // RULE7
        s_d.busy = 1'b0;
        s_d.st = ST_IDLE;
      end
      default: begin
        s_d.st = ST_IDLE;
        s_d.busy = 1'b0;
      end
    endcase
  end

  // ----------------------------------------------------------------
  // state register, frozen while ce_i is low
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      s_q.st <= ST_IDLE;
      s_q.busy <= 1'b0;
      s_q.done <= 1'b0;
      s_q.foreign <= 1'b0;
      s_q.dest <= 1'b0;
      s_q.acc <= ACC_RESET;
      s_q.result <= DATA_RESET;
      s_q.ea <= ADDR_RESET;
      s_q.dbg_pend <= 1'b0;
      s_q.dbg_valid <= 1'b0;
      s_q.dbg_rdata <= DATA_RESET;
    end else if (ce_i) begin
      s_q <= s_d;
    end
  end

  // ----------------------------------------------------------------
  // data file
  // ----------------------------------------------------------------
  general_purpose_file u_file (
    .core_clk_i(core_clk_i),
    .rst_i(rst_i),
    .ce_i(ce_i),
    .port(mem_bus.mem)
  );

  // ----------------------------------------------------------------
  // outputs, straight from the state register
  // ----------------------------------------------------------------
  assign busy_o = s_q.busy;
  assign done_o = s_q.done;
  assign foreign_o = s_q.foreign;
  assign acc_o = s_q.acc;
  assign result_o = s_q.result;
  assign eff_addr_o = s_q.ea;
  assign dbg_valid_o = s_q.dbg_valid;
  assign dbg_rdata_o = s_q.dbg_rdata;
endmodule // nibble_swap_core

// ---- test/nibble_swap_monitor.sv ----
// assertions on the ports of the nibble exchange core
// assumes one clock domain with a synchronous active-high reset
module nibble_swap_monitor (
  input wire logic core_clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  input wire logic instr_valid_i,
  input wire logic [nibble_swap_pkg::INSTR_W-1:0] instr_i,
  input wire logic [nibble_swap_pkg::BANK_W-1:0] bank_select_reg_i,
  input wire logic ext_set_en_i,
  input wire logic [nibble_swap_pkg::ADDR_W-1:0] index_base_i,
  input wire logic busy_o,
  input wire logic done_o,
  input wire logic foreign_o,
  input wire logic [nibble_swap_pkg::DATA_W-1:0] acc_o,
  input wire logic [nibble_swap_pkg::DATA_W-1:0] result_o,
  input wire logic [nibble_swap_pkg::ADDR_W-1:0] eff_addr_o
);
  import nibble_swap_pkg::*;
  logic op;
  logic tk;
  assign op = instr_i[OPC_HI:OPC_LO] == NIBBLE_EXCHANGE_OP;
  assign tk = ce_i && instr_valid_i && !busy_o && op;
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (rst_i);
  swap_twice_a: assert property (
    tk && instr_i[DEST_BIT] ##1 ce_i ##1 (tk && $stable(ext_set_en_i)
    && instr_i == $past(instr_i, 2) && bank_select_reg_i == $past(bank_select_reg_i, 2)) ##1 ce_i
    |=> result_o == {$past(result_o[3:0], 2), $past(result_o[7:4], 2)}) else $error("bad swap");
  acc_dest_a: assert property (
    tk && !instr_i[DEST_BIT] ##1 ce_i |=> acc_o == result_o)
    else $error("acc not loaded");
  acc_kept_a: assert property (
    tk && instr_i[DEST_BIT] |=> $stable(acc_o)[*2])
    else $error("acc changed");
  common_bank_a: assert property (
    tk && !instr_i[BANK_BIT] && (!ext_set_en_i
    || instr_i[7:0] > OFFSET_LIMIT) |=> eff_addr_o == {($past(instr_i[7]) ? ACCESS_HIGH_BANK
    : ACCESS_LOW_BANK), $past(instr_i[7:0])}) else $error("bad common address");
  bank_sel_a: assert property (
    tk && instr_i[BANK_BIT] |=> eff_addr_o ==
    {$past(bank_select_reg_i), $past(instr_i[7:0])}) else $error("bad banked address");
  index_addr_a: assert property (
    tk && !instr_i[BANK_BIT] && ext_set_en_i && instr_i[7:0] <=
    OFFSET_LIMIT |=> eff_addr_o == $past(index_base_i) + $past(instr_i[7:0]))
    else $error("bad indexed address");
  op_timing_a: assert property (
    tk ##1 ce_i |-> busy_o && !foreign_o ##1 done_o && !busy_o)
    else $error("bad op timing");
  foreign_word_a: assert property (
    ce_i && instr_valid_i && !busy_o && !op |=> foreign_o
    && !busy_o && $stable(acc_o)) else $error("bad foreign word");
  cover property (tk && !instr_i[DEST_BIT]);
  cover property (tk && instr_i[BANK_BIT]);
  cover property (tk && ext_set_en_i && !instr_i[BANK_BIT]);
endmodule // nibble_swap_monitor
bind nibble_swap_core nibble_swap_monitor u_nibble_swap_monitor (.*);

// ---- test/tb.sv ----
// self-checking bench driving the nibble exchange core ports directly
// assumes the core package and monitor are compiled first
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic core_clk_i = 0, rst_i = 1, iv = 0, ext = 0, dwe = 0, dre = 0, ce = 1;
  logic [15:0] instr = 16'h0000;
  logic [3:0] bsel = 4'h0;
  logic [11:0] base = 12'h000, daddr = 12'h000, eaddr;
  logic [7:0] dwd = 8'h00, acc, res, drd;
  logic busy, done, frn, dvld;
  int mismatches = 0, total_checks = 0;
  nibble_swap_core u_nibble_swap_core (.core_clk_i(core_clk_i), .rst_i(rst_i), .ce_i(ce),
    .instr_valid_i(iv), .instr_i(instr), .bank_select_reg_i(bsel), .ext_set_en_i(ext),
    .index_base_i(base), .dbg_we_i(dwe), .dbg_re_i(dre), .dbg_addr_i(daddr),
    .dbg_wdata_i(dwd), .busy_o(busy), .done_o(done), .foreign_o(frn), .acc_o(acc),
    .result_o(res), .eff_addr_o(eaddr), .dbg_valid_o(dvld), .dbg_rdata_o(drd));
  initial begin
    forever #25 core_clk_i = ~core_clk_i;
  end
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    total_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic final_report();
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    dwe = 1; daddr = a; dwd = d;
    @(negedge core_clk_i) dwe = 0;
  endtask
  task automatic rd(input logic [11:0] a, input logic [7:0] d);
    dre = 1; daddr = a;
    @(negedge core_clk_i) dre = 0;
    @(negedge core_clk_i) chk(16'({dvld, drd}), 16'({1'h1, d}));
  endtask
  task automatic op(input logic [15:0] w, input logic [11:0] a, input logic [7:0] r, ac);
    iv = 1; instr = w;
    @(negedge core_clk_i) iv = 0;
    chk(16'({busy, eaddr}), 16'({1'h1, a}));
    @(negedge core_clk_i);
    chk(16'({busy, done, frn, res}), 16'({3'h2, r}));
    chk(16'(acc), 16'(ac));
  endtask
  initial begin
    repeat (4) @(negedge core_clk_i);
    rst_i = 0;
    wr(12'h053, 8'h53);
    op(16'h3A53, 12'h053, 8'h35, 8'h00);
    op(16'h3A53, 12'h053, 8'h53, 8'h00);
    rd(12'h053, 8'h53);
    bsel = 4'h2;
    wr(12'h2A7, 8'hC4);
    op(16'h39A7, 12'h2A7, 8'h4C, 8'h4C);
    rd(12'h2A7, 8'hC4);
    wr(12'hF90, 8'h1E);
    op(16'h3A90, 12'hF90, 8'hE1, 8'h4C);
    ext = 1; base = 12'h100;
    wr(12'h15F, 8'h7B);
    op(16'h3A5F, 12'h15F, 8'hB7, 8'h4C);
    wr(12'h060, 8'hA5);
    op(16'h3860, 12'h060, 8'h5A, 8'h5A);
    iv = 1; instr = 16'h5A53;
    @(negedge core_clk_i) iv = 0;
    chk(16'({busy, frn}), 16'h0001);
    @(negedge core_clk_i) chk(16'(acc), 16'h005A);
    ce = 0; iv = 1; instr = 16'h3860;
    @(negedge core_clk_i) chk(16'({busy, done, frn, acc}), 16'({3'h0, 8'h5A}));
    ce = 1;
    op(16'h3860, 12'h060, 8'h5A, 8'h5A);
    final_report();
  end
  initial begin
    repeat (2000) @(posedge core_clk_i);
    mismatches++;
    final_report();
  end
endmodule // tb
